// File: verilog/sgp_map.vh
// Register map, field positions and reset values of the six-bit port
`ifndef SGP_MAP_VH
`define SGP_MAP_VH
`define SGP_IDX_PIN_LEVELS 8'h05
`define SGP_IDX_DIRECTION 8'h85
`define SGP_IDX_PULLUP 8'h95
`define SGP_IDX_CONFIG 8'h96
`define SGP_IDX_ANALOG 8'h9F
`define SGP_IDX_PERIPH 8'hA0
`define SGP_ADDR_PIN_LEVELS 12'h014
`define SGP_ADDR_DIRECTION 12'h214
`define SGP_ADDR_PULLUP 12'h254
`define SGP_ADDR_CONFIG 12'h258
`define SGP_ADDR_ANALOG 12'h27C
`define SGP_ADDR_PERIPH 12'h280
`define SGP_PIN_THREE 3
`define SGP_CFG_GLOBAL_PULLUP 7
`define SGP_CFG_RESET_PIN_FN 0
`define SGP_RST_DIRECTION 6'h3F
`define SGP_RST_LATCH 6'h00
`define SGP_RST_PULLUP 6'h37
`define SGP_RST_CONFIG 8'h80
`define SGP_RST_ANALOG 6'h00
`define SGP_RST_PERIPH 6'h00
`define SGP_PULLUP_MASK 6'h37
`define SGP_RESP_OKAY 2'h0
`define SGP_RESP_SLVERR 2'h2
`endif

// File: verilog/sgp_gpio_port.v
// Six-bit general purpose port with an AXI4-Lite register slave
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "sgp_map.vh"
module sgp_gpio_port (
	input wire aclk,
	input wire aresetn,
	input wire [11:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [5:0] pin_in,
	output reg [5:0] pin_out,
	output reg [5:0] pin_oe,
	output reg [5:0] pin_pullup_en,
	input wire [5:0] periph_out,
	input wire [5:0] periph_oe
);
	localparam ST_IDLE = 3'b001;
	localparam ST_RESP = 3'b010;
	localparam ST_DONE = 3'b100;

	reg [5:0] pin_meta_r;
	reg [5:0] pin_sync_r;
	reg [5:0] latch_r;
	reg [5:0] direction_r;
	reg [5:0] pullup_r;
	reg [7:0] config_r;
	reg [5:0] analog_r;
	reg [5:0] periph_en_r;
	reg [2:0] wr_state_r;
	reg [11:0] aw_addr_r;
	reg aw_have_r;
	reg [31:0] w_data_r;
	reg w_have_r;
	reg w_lane0_r;

	wire [5:0] levels_view;
	wire [5:0] dir_eff;
	wire [5:0] out_nxt;
	wire [5:0] oe_nxt;
	wire [5:0] pu_nxt;
	wire wr_go;
	wire [11:0] wr_addr;
	wire [31:0] wr_data;
	wire [5:0] rmw_value;
	wire wr_lane0;
	wire wr_store;
	wire we_latch;
	wire we_direction;
	wire we_pullup;
	wire we_config;
	wire we_analog;
	wire we_periph;
	reg [31:0] rd_nxt;
	reg rd_err_nxt;

	// Pins come from the board, so two stages before any use
	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_meta_r <= 6'h00;
			pin_sync_r <= 6'h00;
		end else begin
			pin_meta_r <= pin_in;
			pin_sync_r <= pin_meta_r;
		end
	end

	// Per-pin view of levels, drivers and pull-ups
	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1) begin : g_pin
			if (g == `SGP_PIN_THREE) begin : g_in_only
				// Input only: no peripheral may drive it either
				assign dir_eff[g] = 1'b1;
				assign levels_view[g] = pin_sync_r[g] &
					~config_r[`SGP_CFG_RESET_PIN_FN] & ~analog_r[g];
				assign pu_nxt[g] = 1'b0;
				assign oe_nxt[g] = 1'b0;
				assign out_nxt[g] = latch_r[g];
			end else begin : g_bidir
				assign dir_eff[g] = direction_r[g];
				assign levels_view[g] = pin_sync_r[g] & ~analog_r[g];
				// Pull-up off when the direction bit makes it an output or globally disabled
				assign pu_nxt[g] = pullup_r[g] & dir_eff[g] &
					~config_r[`SGP_CFG_GLOBAL_PULLUP];
				// Peripheral wins the pin while enabled
				assign oe_nxt[g] = periph_en_r[g] ? periph_oe[g] :
					~dir_eff[g];
				assign out_nxt[g] = periph_en_r[g] ? periph_out[g] :
					latch_r[g];
			end
		end
	endgenerate

	// Each pin output straight from its own flop
	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_out <= 6'h00;
		end else begin
			pin_out <= out_nxt;
		end
	end

	// Drivers off during reset, so the board sees inputs only
	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_oe <= 6'h00;
		end else begin
			pin_oe <= oe_nxt;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_pullup_en <= 6'h00;
		end else begin
			pin_pullup_en <= pu_nxt;
		end
	end

	// Write channel: address and data taken in either order
	assign wr_addr = s_axi_awvalid & s_axi_awready ? s_axi_awaddr :
		aw_addr_r;
	assign wr_data = s_axi_wvalid & s_axi_wready ? s_axi_wdata : w_data_r;
	assign wr_go = (wr_state_r == ST_IDLE) &
		(aw_have_r | (s_axi_awvalid & s_axi_awready)) &
		(w_have_r | (s_axi_wvalid & s_axi_wready));
	// Written bits when lane 0 is strobed, else the sampled pin levels
	// Lane 0 remembered in case data comes before address
	assign wr_lane0 = s_axi_wvalid & s_axi_wready ? s_axi_wstrb[0] :
		w_lane0_r;
	assign rmw_value = wr_lane0 ? wr_data[5:0] : levels_view;

	// Lane 0 holds every bit; without it nothing is stored
	assign wr_store = wr_go & wr_lane0;

	always @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_r <= ST_IDLE;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SGP_RESP_OKAY;
			aw_addr_r <= 12'h000;
			aw_have_r <= 1'b0;
			w_data_r <= 32'h00000000;
			w_have_r <= 1'b0;
			w_lane0_r <= 1'b0;
		end else begin
			case (wr_state_r)
				ST_IDLE: begin
					s_axi_awready <= ~aw_have_r &
						~(s_axi_awvalid & s_axi_awready);
					s_axi_wready <= ~w_have_r &
						~(s_axi_wvalid & s_axi_wready);
					if (s_axi_awvalid & s_axi_awready) begin
						aw_addr_r <= s_axi_awaddr;
						aw_have_r <= 1'b1;
					end
					if (s_axi_wvalid & s_axi_wready) begin
						w_data_r <= s_axi_wdata;
						w_lane0_r <= s_axi_wstrb[0];
						w_have_r <= 1'b1;
					end
					if (wr_go) begin
						s_axi_awready <= 1'b0;
						s_axi_wready <= 1'b0;
						wr_state_r <= ST_RESP;
					end
				end
				ST_RESP: begin
					s_axi_bvalid <= 1'b1;
					s_axi_bresp <= rd_err_w(aw_addr_r) ?
						`SGP_RESP_SLVERR : `SGP_RESP_OKAY;
					wr_state_r <= ST_DONE;
				end
				ST_DONE: begin
					if (s_axi_bready) begin
						s_axi_bvalid <= 1'b0;
						aw_have_r <= 1'b0;
						w_have_r <= 1'b0;
						s_axi_awready <= 1'b1;
						s_axi_wready <= 1'b1;
						wr_state_r <= ST_IDLE;
					end
				end
				default: begin
					wr_state_r <= ST_IDLE;
				end
			endcase
		end
	end

	function rd_err_w;
		input [11:0] a;
		begin
			rd_err_w = !(a == `SGP_ADDR_PIN_LEVELS ||
				a == `SGP_ADDR_DIRECTION || a == `SGP_ADDR_PULLUP ||
				a == `SGP_ADDR_CONFIG || a == `SGP_ADDR_ANALOG ||
				a == `SGP_ADDR_PERIPH);
		end
	endfunction

	// One store per register; unmapped addresses store nothing
	assign we_latch = wr_store & (wr_addr == `SGP_ADDR_PIN_LEVELS);
	assign we_direction = wr_store & (wr_addr == `SGP_ADDR_DIRECTION);
	assign we_pullup = wr_store & (wr_addr == `SGP_ADDR_PULLUP);
	assign we_config = wr_store & (wr_addr == `SGP_ADDR_CONFIG);
	assign we_analog = wr_store & (wr_addr == `SGP_ADDR_ANALOG);
	assign we_periph = wr_store & (wr_addr == `SGP_ADDR_PERIPH);

	// Latch only; reads show the pins, not this
	always @(posedge aclk) begin
		if (!aresetn) begin
			latch_r <= `SGP_RST_LATCH;
		end else if (we_latch) begin
			latch_r <= rmw_value;
		end
	end

	// Bit 3 forced: pin three can never become an output
	always @(posedge aclk) begin
		if (!aresetn) begin
			direction_r <= `SGP_RST_DIRECTION;
		end else if (we_direction) begin
			direction_r <= wr_data[5:0] | 6'h08;
		end
	end

	// Mask keeps pin three's pull-up bit clear
	always @(posedge aclk) begin
		if (!aresetn) begin
			pullup_r <= `SGP_RST_PULLUP;
		end else if (we_pullup) begin
			pullup_r <= wr_data[5:0] & `SGP_PULLUP_MASK;
		end
	end

	// Bit 7 set turns every pull-up off, hence its reset value
	always @(posedge aclk) begin
		if (!aresetn) begin
			config_r <= `SGP_RST_CONFIG;
		end else if (we_config) begin
			config_r <= {wr_data[7], 6'h00, wr_data[0]};
		end
	end

	// Analog pins read zero but keep their drivers
	always @(posedge aclk) begin
		if (!aresetn) begin
			analog_r <= `SGP_RST_ANALOG;
		end else if (we_analog) begin
			analog_r <= wr_data[5:0];
		end
	end

	// Enable hands the pin to its peripheral, except pin three, which stays an input
	always @(posedge aclk) begin
		if (!aresetn) begin
			periph_en_r <= `SGP_RST_PERIPH;
		end else if (we_periph) begin
			periph_en_r <= wr_data[5:0];
		end
	end

	// Read data; upper bits always zero
	always @* begin
		rd_nxt = 32'h00000000;
		rd_err_nxt = 1'b0;
		case (s_axi_araddr)
			`SGP_ADDR_PIN_LEVELS: rd_nxt[5:0] = levels_view;
			`SGP_ADDR_DIRECTION: rd_nxt[5:0] = dir_eff;
			`SGP_ADDR_PULLUP: rd_nxt[5:0] = pullup_r;
			`SGP_ADDR_CONFIG: rd_nxt[7:0] = config_r;
			`SGP_ADDR_ANALOG: rd_nxt[5:0] = analog_r;
			`SGP_ADDR_PERIPH: rd_nxt[5:0] = periph_en_r;
			default: rd_err_nxt = 1'b1;
		endcase
	end

	// Read handshake; one read under way at a time
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

	// Data held while the answer waits for rready
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `SGP_RESP_OKAY;
		end else if (!s_axi_rvalid & s_axi_arvalid & s_axi_arready) begin
			s_axi_rdata <= rd_nxt;
			s_axi_rresp <= rd_err_nxt ? `SGP_RESP_SLVERR : `SGP_RESP_OKAY;
		end
	end
endmodule // sgp_gpio_port
`default_nettype wire

// File: bench/sgp_props_properties.sv
// Bus and pin properties of the six-bit port
`timescale 1ns/1ps
`default_nettype none
module sgp_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [5:0] pin_oe,
	input wire logic [5:0] pin_pullup_en,
	input wire logic [5:0] periph_oe
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_b_wait;
		s_axi_bvalid && !s_axi_bready;
	endsequence
	a_write_resp: assert property
		(s_wr_taken |-> ##2 s_axi_bvalid) else $error("late write response");
	a_resp_held: assert property
		(s_b_wait |=> s_axi_bvalid) else $error("write response dropped");
	a_read_resp: assert property
		(s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read");
	a_rdata_held: assert property
		(s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_high_bits_zero: assert property
		(s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("high bits set");
	a_pin3_input: assert property
		(!pin_oe[3] && !pin_pullup_en[3]) else $error("pin three driven or pulled");
	a_pullup_out_off: assert property
		((pin_oe & pin_pullup_en & ~$past(periph_oe)) == 6'h00)
		else $error("pull-up on driven pin");
	a_reset_quiet: assert property
		($rose(aresetn) |-> pin_oe == 6'h00 && pin_pullup_en == 6'h00)
		else $error("pins active after reset");
endmodule // sgp_props
bind sgp_gpio_port sgp_props i_sgp_props (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
	.pin_oe, .pin_pullup_en, .periph_oe);
`default_nettype wire

// File: bench/sgp_pin_board.sv
// Board model of the six pins
`timescale 1ns/1ps
`default_nettype none
module sgp_pin_board (
	input wire logic [5:0] pin_out,
	input wire logic [5:0] pin_oe,
	input wire logic [5:0] pin_pullup_en,
	input wire logic [5:0] ext,
	output logic [5:0] pin_in
);
	// Driver wins, then pull-up, else the board level
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_pullup_en) |
		(~pin_oe & ~pin_pullup_en & ext);
endmodule // sgp_pin_board
`default_nettype wire

// File: bench/tb.sv
// Testbench of the six-bit port
`timescale 1ns/1ps
`default_nettype none
`include "sgp_map.vh"
module tb;
	typedef struct packed {
		logic [11:0] a;
		logic [7:0] wd, bef, aft;
		logic [1:0] resp;
	} sgp_row_t;
	logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic [11:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rdv;
	logic [3:0] ws = 0;
	logic [1:0] rsp;
	logic [5:0] ext = 0;
	wire [5:0] po, poe, ppu, pin;
	wire awr, wrd, bv, arr, rv;
	wire [1:0] br, rr;
	wire [31:0] rdat;
	int failures = 0, n_checks = 0, cyc = 0;
	sgp_row_t rows [7] = '{
		'{`SGP_ADDR_DIRECTION, 8'hFF, 8'h3F, 8'h3F, 2'h0},
		'{`SGP_ADDR_DIRECTION, 8'h00, 8'h3F, 8'h08, 2'h0},
		'{`SGP_ADDR_PULLUP, 8'h3F, 8'h37, 8'h37, 2'h0},
		'{`SGP_ADDR_CONFIG, 8'h81, 8'h80, 8'h81, 2'h0},
		'{`SGP_ADDR_ANALOG, 8'h03, 8'h00, 8'h03, 2'h0},
		'{`SGP_ADDR_PERIPH, 8'h00, 8'h00, 8'h00, 2'h0},
		'{12'h100, 8'h55, 8'h00, 8'h00, 2'h2}};
	sgp_gpio_port i_sgp_gpio_port (.aclk, .aresetn, .s_axi_awaddr(awa),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
		.s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .pin_in(pin),
		.pin_out(po), .pin_oe(poe), .pin_pullup_en(ppu),
		.periph_out(6'h00), .periph_oe(6'h00));
	sgp_pin_board i_sgp_pin_board (.pin_out(po), .pin_oe(poe),
		.pin_pullup_en(ppu), .ext, .pin_in(pin));
	initial forever #2 aclk = ~aclk;
	always @(posedge aclk) if (++cyc == 3000) begin
		failures++;
		close_out;
	end
	task close_out;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task pins(input logic [5:0] o, input logic [5:0] e, input logic [5:0] u);
		chk({26'h0, po}, {26'h0, o});
		chk({26'h0, poe}, {26'h0, e});
		chk({26'h0, ppu}, {26'h0, u});
	endtask
	task wr_reg(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
		awa <= a; wd <= {24'h0, d}; ws <= s; awv <= 1; wv <= 1; bry <= 1;
		do begin
			@(posedge aclk);
			if (awr) awv <= 0;
			if (wrd) wv <= 0;
		end while (!bv);
		rsp = br; bry <= 0;
		repeat (3) @(posedge aclk);
	endtask
	task rd_reg(input logic [11:0] a);
		ara <= a; arv <= 1; rry <= 1;
		do begin
			@(posedge aclk);
			if (arr) arv <= 0;
		end while (!rv);
		rdv = rdat; rsp = rr; rry <= 0;
		@(posedge aclk);
	endtask
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		foreach (rows[i]) begin
			rd_reg(rows[i].a);
			chk(rdv, {24'h0, rows[i].bef});
			chk({30'h0, rsp}, {30'h0, rows[i].resp});
			wr_reg(rows[i].a, rows[i].wd, 4'h1);
			chk({30'h0, rsp}, {30'h0, rows[i].resp});
			rd_reg(rows[i].a);
			chk(rdv, {24'h0, rows[i].aft});
		end
		ext <= 6'h3F;
		wr_reg(`SGP_ADDR_PIN_LEVELS, 8'h15, 4'h1);
		pins(6'h15, 6'h37, 6'h00);
		rd_reg(`SGP_ADDR_PIN_LEVELS);
		chk(rdv, 32'h14);
		wr_reg(`SGP_ADDR_CONFIG, 8'h00, 4'h1);
		wr_reg(`SGP_ADDR_ANALOG, 8'h00, 4'h1);
		rd_reg(`SGP_ADDR_PIN_LEVELS);
		chk(rdv, 32'h1D);
		wr_reg(`SGP_ADDR_PIN_LEVELS, 8'h00, 4'h0);
		pins(6'h15, 6'h37, 6'h00);
		ext <= 6'h00;
		wr_reg(`SGP_ADDR_DIRECTION, 8'h3F, 4'h1);
		pins(6'h15, 6'h00, 6'h37);
		rd_reg(`SGP_ADDR_PIN_LEVELS);
		chk(rdv, 32'h37);
		wr_reg(`SGP_ADDR_CONFIG, 8'h80, 4'h1);
		pins(6'h15, 6'h00, 6'h00);
		wr_reg(`SGP_ADDR_DIRECTION, 8'h00, 4'h1);
		pins(6'h15, 6'h37, 6'h00);
		wr_reg(`SGP_ADDR_PERIPH, 8'h01, 4'h1);
		pins(6'h14, 6'h36, 6'h00);
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		pins(6'h00, 6'h00, 6'h00);
		aresetn <= 1;
		@(posedge aclk);
		rd_reg(`SGP_ADDR_DIRECTION);
		chk(rdv, 32'h3F);
		close_out;
	end
endmodule // tb
`default_nettype wire
